// ==== logic/gpr_map.svh ====
// Gyro power block constants
`ifndef GPR_MAP_SVH
`define GPR_MAP_SVH

// Bus offsets
`define GPR_CTRL_OFFSET 8'h00
`define GPR_STATUS_OFFSET 8'h04

// Control fields
`define GPR_CTRL_ROLL_DIRECT 0
`define GPR_CTRL_ROLL_FORCE 1
`define GPR_CTRL_THIRTEEN 2
`define GPR_CTRL_AMP_BACKUP_A 3
`define GPR_CTRL_WIDTH 4
`define GPR_CTRL_RESET 4'h0

// Status width
`define GPR_STATUS_WIDTH 18

// Clock and time figures
`define GPR_CLK_PERIOD_NS 8
`define GPR_NS_PER_MS 1000000
`define GPR_ON_DELAY_MS 90
`define GPR_HOLD_MIN 3
`define GPR_MS_PER_MIN 60000

// Derived counts
`define GPR_TICK_CYCLES (`GPR_NS_PER_MS / `GPR_CLK_PERIOD_NS)
`define GPR_ON_TICKS (`GPR_ON_DELAY_MS)
`define GPR_HOLD_TICKS (`GPR_HOLD_MIN * `GPR_MS_PER_MIN)

`endif

// ==== logic/gpr_pkg.sv ====
// Gyro power block types
`default_nettype none
package gpr_pkg;
    // Bus data word
    typedef logic [31:0] gpr_word_t;
    // Bus byte address
    typedef logic [7:0] gpr_addr_t;
    // Timer states, one-hot
    typedef enum logic [3:0] {
        GPR_T_OFF  = 4'b0001,
        GPR_T_ARM  = 4'b0010,
        GPR_T_ON   = 4'b0100,
        GPR_T_HOLD = 4'b1000
    } gpr_tstate_t;
endpackage
`default_nettype wire

// ==== logic/gpr_sync.sv ====
// Two-flop pin synchroniser
`default_nettype none
module gpr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and synchronised copy
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q; // First stage

    ////////////////////////////////////////
    // Two stages
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= pin_i;
            sync_o <= meta_q;
        end
    end
endmodule // gpr_sync
`default_nettype wire

// ==== logic/gpr_timer.sv ====
// Gyro power timer: on delay, hold, settle
`include "gpr_map.svh"
`default_nettype none
module gpr_timer #(
    parameter logic [16:0] TICK_CYCLES = 17'(`GPR_TICK_CYCLES),
    parameter logic [17:0] HOLD_TICKS = 18'(`GPR_HOLD_TICKS)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request in, timed powers out
    input wire logic request_i,
    output logic delayed_o,
    output logic inverter_o,
    output logic settled_o
);
    import gpr_pkg::*;

    localparam logic [17:0] ON_TICKS = 18'(`GPR_ON_TICKS);

    logic [16:0] tick_q; // Cycle divider
    logic tick; // One-cycle 1 ms enable
    gpr_tstate_t st_q, st_d;
    logic [17:0] cnt_q, cnt_d; // Ticks in state

    assign tick = (tick_q == TICK_CYCLES - 17'h1);

    ////////////////////////////////////////
    // Next state
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            GPR_T_OFF: begin
                if (request_i) begin
                    st_d = GPR_T_ARM;
                    cnt_d = '0;
                end
            end
            GPR_T_ARM: begin
                // 90 ms wait lets the latch settle
                if (!request_i) begin
                    st_d = inverter_o ? GPR_T_HOLD : GPR_T_OFF;
                    cnt_d = '0;
                end else if (tick) begin
                    if (cnt_q == ON_TICKS - 18'h1) begin
                        st_d = GPR_T_ON;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 18'h1;
                    end
                end
            end
            GPR_T_ON: begin
                if (!request_i) begin
                    st_d = GPR_T_HOLD;
                    cnt_d = '0;
                end else if (tick && cnt_q != HOLD_TICKS) begin
                    cnt_d = cnt_q + 18'h1; // Settle count
                end
            end
            GPR_T_HOLD: begin
                // Inverter held after request drops
                if (request_i) begin
                    st_d = GPR_T_ARM;
                    cnt_d = '0;
                end else if (tick) begin
                    if (cnt_q == HOLD_TICKS - 18'h1) begin
                        st_d = GPR_T_OFF;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 18'h1;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////
    // Divider, state, outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_q <= '0;
            st_q <= GPR_T_OFF;
            cnt_q <= '0;
            delayed_o <= 1'b0;
            inverter_o <= 1'b0;
            settled_o <= 1'b0;
        end else begin
            tick_q <= tick ? 17'h0 : tick_q + 17'h1;
            st_q <= st_d;
            cnt_q <= cnt_d;
            delayed_o <= (st_d == GPR_T_ON);
            inverter_o <= (st_d == GPR_T_ON) || (st_d == GPR_T_HOLD) || ((st_d == GPR_T_ARM) && inverter_o);
            settled_o <= (st_d == GPR_T_ON) && (cnt_d == HOLD_TICKS);
        end
    end
endmodule // gpr_timer
`default_nettype wire

// ==== logic/gpr_top.sv ====
// Gyro power and amplifier control
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`include "gpr_map.svh"
`default_nettype none

// Overview of operation
// - Roll gyro power follows inverter power
// - Inverter power holds 3 min after request drops
// - Pitch/yaw power needs inverter on, latch clear
// - Latch sets only while delayed power off
// - Powers follow request rise by 90 ms
// - Latch clears on reacquisition or sun gate off
// - Gyro-on or inertial command clears latch
// - Pitch/yaw integrators follow inertial-mode command
// - Roll integrator needs settled plus any cause
// - Integrators feed amplifiers ungated
// - Negative turn when both polarity commands off
// - Roll execute follows command; yaw needs roll off
// - Each increment command while settled gives one 2-deg step
// - Gyro rates always wired while powered
// - Accelerometer power matches pitch/yaw gyro power
// - Capture held until release, backup or raw gyro-on command
// - Derived rate disabled when pitch/yaw gyros on
// - Roll amp set by arming, backups, capture release or raw gyro-on command, stays
// - Pitch/yaw amp equals roll, off in thrust
// - Request drives 3 min timer and settled signal
module gpr_top #(
    parameter logic [16:0] TICK_CYCLES = 17'(`GPR_TICK_CYCLES),
    parameter logic [17:0] HOLD_TICKS = 18'(`GPR_HOLD_TICKS)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire gpr_pkg::gpr_addr_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire gpr_pkg::gpr_word_t wb_dat_i,
    output gpr_pkg::gpr_word_t wb_dat_o,
    output logic wb_ack_o,
    // Power request and sensor flags
    input wire logic gyro_power_request_i,
    input wire logic star_acquired_i,
    input wire logic sun_gate_i,
    input wire logic power_up_acq_flag_i,
    input wire logic flyback_sweep_i,
    input wire logic pyro_arm_switch_i,
    // Sequencer commands
    input wire logic stray_light_cmd_i,
    input wire logic gyro_on_seq_cmd_i,
    input wire logic inertial_mode_cmd_i,
    input wire logic turn_polarity_seq_i,
    input wire logic roll_turn_cmd_i,
    input wire logic roll_turn_raw_i,
    input wire logic yaw_turn_cmd_i,
    input wire logic capture_release_cmd_i,
    input wire logic switch_amp_backup_a_i,
    input wire logic gyro_on_raw_cmd_i,
    input wire logic thrust_vector_mode_cmd_i,
    // Direct commands
    input wire logic roll_gyro_direct_latched_i,
    input wire logic roll_gyro_force_latched_i,
    input wire logic backup_direct_cmd_thirteen_i,
    input wire logic roll_increment_pos_cmd_i,
    input wire logic roll_increment_neg_cmd_i,
    // Gyro power and timer outputs
    output logic inverter_power_on_o,
    output logic delayed_gyro_power_o,
    output logic gyro_settled_o,
    output logic roll_gyro_power_o,
    output logic pitch_yaw_gyro_power_o,
    output logic roll_only_o,
    // Integrators and turns
    output logic pitch_yaw_integ_en_o,
    output logic roll_integ_en_o,
    output logic negative_turn_o,
    output logic roll_turn_exec_o,
    output logic yaw_turn_exec_o,
    output logic roll_incr_pos_o,
    output logic roll_incr_neg_o,
    // Accelerometer, derived rate, amplifiers
    output logic accel_power_o,
    output logic capture_release_o,
    output logic pitch_yaw_drate_disable_o,
    output logic roll_switch_amp_enable_o,
    output logic pitch_yaw_switch_amp_enable_o
);
    import gpr_pkg::*;

    ////////////////////////////////////////
    // Pin synchronisation

    localparam int NPIN = 22;

    logic [NPIN-1:0] pins; // Raw pin vector
    logic [NPIN-1:0] pins_s; // Synchronised pin vector

    // Pins in fixed order
    assign pins = {gyro_power_request_i, star_acquired_i, sun_gate_i, power_up_acq_flag_i,
                   flyback_sweep_i, pyro_arm_switch_i, stray_light_cmd_i, gyro_on_seq_cmd_i,
                   inertial_mode_cmd_i, turn_polarity_seq_i, roll_turn_cmd_i, roll_turn_raw_i,
                   yaw_turn_cmd_i, capture_release_cmd_i, switch_amp_backup_a_i, gyro_on_raw_cmd_i,
                   thrust_vector_mode_cmd_i, roll_gyro_direct_latched_i, roll_gyro_force_latched_i,
                   backup_direct_cmd_thirteen_i, roll_increment_pos_cmd_i, roll_increment_neg_cmd_i};

    // Two flops before any logic
    gpr_sync #(
        .W(NPIN)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pins),
        .sync_o(pins_s)
    );

    // Synchronised copies
    wire gyro_power_request;
    wire star_acquired;
    wire sun_gate;
    wire power_up_acq_flag;
    wire flyback_sweep;
    wire pyro_arm_switch;
    wire stray_light_cmd;
    wire gyro_on_seq_cmd;
    wire inertial_mode_cmd;
    wire turn_polarity_seq;
    wire roll_turn_cmd;
    wire roll_turn_raw;
    wire yaw_turn_cmd;
    wire capture_release_cmd;
    wire amp_backup_pin;
    wire gyro_on_raw_cmd;
    wire thrust_vector_mode_cmd;
    wire roll_direct_pin;
    wire roll_force_pin;
    wire thirteen_pin;
    wire roll_increment_pos_cmd;
    wire roll_increment_neg_cmd;

    // Unpack in the same order
    assign {gyro_power_request, star_acquired, sun_gate, power_up_acq_flag,
            flyback_sweep, pyro_arm_switch, stray_light_cmd, gyro_on_seq_cmd,
            inertial_mode_cmd, turn_polarity_seq, roll_turn_cmd, roll_turn_raw,
            yaw_turn_cmd, capture_release_cmd, amp_backup_pin, gyro_on_raw_cmd,
            thrust_vector_mode_cmd, roll_direct_pin, roll_force_pin,
            thirteen_pin, roll_increment_pos_cmd, roll_increment_neg_cmd} = pins_s;

    ////////////////////////////////////////
    // Register bus

    logic [`GPR_CTRL_WIDTH-1:0] ctrl_q; // Software direct commands
    logic [`GPR_STATUS_WIDTH-1:0] status; // Output snapshot

    wire bus_req = wb_cyc_i && wb_stb_i; // Request present
    wire hit_ctrl = (wb_adr_i == `GPR_CTRL_OFFSET); // Control decode
    wire hit_status = (wb_adr_i == `GPR_STATUS_OFFSET); // Status decode
    wire ctrl_wr = bus_req && wb_ack_o && wb_we_i && hit_ctrl && wb_sel_i[0]; // Write on ack edge

    // Read mux; unmapped reads give zero
    wire [31:0] rd_data = hit_ctrl ? {{(32 - `GPR_CTRL_WIDTH){1'b0}}, ctrl_q} :
                          hit_status ? {{(32 - `GPR_STATUS_WIDTH){1'b0}}, status} : 32'h0;

    // Status bits
    assign status = {pitch_yaw_switch_amp_enable_o, roll_switch_amp_enable_o, pitch_yaw_drate_disable_o,
                     capture_release_o, accel_power_o, roll_incr_neg_o, roll_incr_pos_o,
                     yaw_turn_exec_o, roll_turn_exec_o, negative_turn_o, roll_integ_en_o,
                     pitch_yaw_integ_en_o, roll_only_o, pitch_yaw_gyro_power_o, roll_gyro_power_o,
                     gyro_settled_o, delayed_gyro_power_o, inverter_power_on_o};

    // Ack one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `GPR_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= wb_dat_i[`GPR_CTRL_WIDTH-1:0];
        end
    end

    // Direct commands: pin or software copy
    wire roll_gyro_direct_latched = roll_direct_pin || ctrl_q[`GPR_CTRL_ROLL_DIRECT];
    wire roll_gyro_force_latched = roll_force_pin || ctrl_q[`GPR_CTRL_ROLL_FORCE];
    wire backup_direct_cmd_thirteen = thirteen_pin || ctrl_q[`GPR_CTRL_THIRTEEN];
    wire switch_amp_backup_a = amp_backup_pin || ctrl_q[`GPR_CTRL_AMP_BACKUP_A];

    ////////////////////////////////////////
    // Gyro power timer

    logic delayed_gyro_power; // Pitch/yaw switching power
    logic inverter_power_on; // Inverter relay drive
    logic gyro_settled; // Gyro data usable

    // Request drives the timed powers
    gpr_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .HOLD_TICKS(HOLD_TICKS)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .request_i(gyro_power_request),
        .delayed_o(delayed_gyro_power),
        .inverter_o(inverter_power_on),
        .settled_o(gyro_settled)
    );

    ////////////////////////////////////////
    // Roll-only latch

    logic roll_only_q, roll_only_d; // Latch state

    // Roll-only causes
    wire roll_only_cause = !star_acquired || stray_light_cmd || roll_gyro_direct_latched || roll_gyro_force_latched;
    // No set once delayed power is on: relay arcing
    wire roll_only_set = roll_only_cause && !delayed_gyro_power;
    // Clear on reacquisition, sun loss, gyro commands
    wire roll_only_clr = (!roll_only_cause && !delayed_gyro_power) || !sun_gate
                         || gyro_on_seq_cmd || inertial_mode_cmd;

    // Clear has priority: sun gate loss must give all gyros
    always_comb begin
        roll_only_d = roll_only_q;
        if (roll_only_clr) begin
            roll_only_d = 1'b0;
        end else if (roll_only_set) begin
            roll_only_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            roll_only_q <= 1'b0;
        end else begin
            roll_only_q <= roll_only_d;
        end
    end

    ////////////////////////////////////////
    // Increment edge detect

    logic pos_prev_q; // Last positive
    logic neg_prev_q; // Last negative

    // One step per new settled command
    wire incr_pos = roll_increment_pos_cmd && !pos_prev_q && gyro_settled;
    wire incr_neg = roll_increment_neg_cmd && !neg_prev_q && gyro_settled;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_prev_q <= 1'b0;
            neg_prev_q <= 1'b0;
        end else begin
            pos_prev_q <= roll_increment_pos_cmd;
            neg_prev_q <= roll_increment_neg_cmd;
        end
    end

    ////////////////////////////////////////
    // Decoded control terms

    // Shared pitch/yaw power term
    wire py_power = inverter_power_on && !roll_only_q;
    // Roll integrator causes
    wire roll_integ = gyro_settled && (inertial_mode_cmd || (power_up_acq_flag && stray_light_cmd)
                      || flyback_sweep || roll_gyro_direct_latched);
    // Release and backups
    wire release_req = capture_release_cmd || gyro_on_raw_cmd || backup_direct_cmd_thirteen;
    // Roll amp sources
    wire amp_on_req = pyro_arm_switch || switch_amp_backup_a || release_req;
    // Next roll amp enable
    wire roll_amp_d = roll_switch_amp_enable_o || amp_on_req;

    ////////////////////////////////////////
    // Outputs: gyro power

    // Timer and power outputs; rates wired whenever powered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inverter_power_on_o <= 1'b0;
            delayed_gyro_power_o <= 1'b0;
            gyro_settled_o <= 1'b0;
            roll_gyro_power_o <= 1'b0;
            pitch_yaw_gyro_power_o <= 1'b0;
            roll_only_o <= 1'b0;
        end else begin
            inverter_power_on_o <= inverter_power_on;
            delayed_gyro_power_o <= delayed_gyro_power;
            gyro_settled_o <= gyro_settled;
            roll_gyro_power_o <= inverter_power_on;
            pitch_yaw_gyro_power_o <= py_power;
            roll_only_o <= roll_only_q;
        end
    end

    ////////////////////////////////////////
    // Outputs: integrators, turns

    // Integrator enables feed amplifiers directly
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pitch_yaw_integ_en_o <= 1'b0;
            roll_integ_en_o <= 1'b0;
            negative_turn_o <= 1'b0;
            roll_turn_exec_o <= 1'b0;
            yaw_turn_exec_o <= 1'b0;
            roll_incr_pos_o <= 1'b0;
            roll_incr_neg_o <= 1'b0;
        end else begin
            pitch_yaw_integ_en_o <= inertial_mode_cmd;
            roll_integ_en_o <= roll_integ;
            negative_turn_o <= !turn_polarity_seq && !backup_direct_cmd_thirteen;
            // Command length sets turn size
            roll_turn_exec_o <= roll_turn_cmd;
            yaw_turn_exec_o <= yaw_turn_cmd && !roll_turn_raw;
            roll_incr_pos_o <= incr_pos;
            roll_incr_neg_o <= incr_neg;
        end
    end

    ////////////////////////////////////////
    // Outputs: accelerometer, amps

    // Release and roll amp stick until reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_power_o <= 1'b0;
            capture_release_o <= 1'b0;
            pitch_yaw_drate_disable_o <= 1'b0;
            roll_switch_amp_enable_o <= 1'b0;
            pitch_yaw_switch_amp_enable_o <= 1'b0;
        end else begin
            accel_power_o <= py_power;
            capture_release_o <= capture_release_o || release_req;
            pitch_yaw_drate_disable_o <= py_power;
            roll_switch_amp_enable_o <= roll_amp_d;
            pitch_yaw_switch_amp_enable_o <= roll_amp_d && !thrust_vector_mode_cmd;
        end
    end
endmodule // gpr_top
`default_nettype wire

// ==== tb/gpr_props.sv ====
// Port checks for the gyro power block
`include "gpr_map.svh"
`default_nettype none
module gpr_props #(
    parameter logic [16:0] TICK_CYCLES = 17'(`GPR_TICK_CYCLES),
    parameter logic [17:0] HOLD_TICKS = 18'(`GPR_HOLD_TICKS)
) (
    // Clock, reset and watched pins
    input wire logic clk_i, rst_i, gyro_power_request_i, inertial_mode_cmd_i,
    input wire logic roll_turn_cmd_i, roll_turn_raw_i, yaw_turn_cmd_i,
    input wire logic roll_increment_pos_cmd_i, thrust_vector_mode_cmd_i,
    // Watched outputs
    input wire logic inverter_power_on_o, delayed_gyro_power_o, roll_gyro_power_o,
    input wire logic pitch_yaw_gyro_power_o, pitch_yaw_integ_en_o, roll_turn_exec_o,
    input wire logic yaw_turn_exec_o, roll_incr_pos_o, accel_power_o,
    input wire logic pitch_yaw_drate_disable_o, roll_switch_amp_enable_o,
    input wire logic pitch_yaw_switch_amp_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Turn-on delay bounds
    localparam int ON_LO = 89 * TICK_CYCLES;
    localparam int ON_HI = 91 * TICK_CYCLES + 8;
    logic [2:0] age_q; // Edges since reset, held at 4
    logic [31:0] run_q; // Cycles since request change
    logic req_q; // Request pin one cycle ago
    wire up = age_q[2];
    ////////////////////////////////////////////////////////////////
    // Helper counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            age_q <= 3'h0;
            run_q <= 32'h0;
            req_q <= 1'b0;
        end else begin
            age_q <= age_q + {2'h0, !up};
            run_q <= (gyro_power_request_i != req_q) ? 32'h0 : run_q + 32'h1;
            req_q <= gyro_power_request_i;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ROLL_PWR: assert property (roll_gyro_power_o == inverter_power_on_o)
        else $error("roll power off inverter");
    AST_ACC_DRATE: assert property (accel_power_o == pitch_yaw_gyro_power_o
        && pitch_yaw_drate_disable_o == pitch_yaw_gyro_power_o) else $error("accel or drate");
    AST_PY_INTEG: assert property (up |-> pitch_yaw_integ_en_o == $past(inertial_mode_cmd_i, 3))
        else $error("py integ");
    AST_EXEC: assert property (up |-> roll_turn_exec_o == $past(roll_turn_cmd_i, 3)
        && yaw_turn_exec_o == ($past(yaw_turn_cmd_i, 3) && !$past(roll_turn_raw_i, 3))) else $error("exec");
    AST_INCR: assert property (roll_incr_pos_o |-> $past(roll_increment_pos_cmd_i, 3)
        && !$past(roll_increment_pos_cmd_i, 4) ##1 !roll_incr_pos_o) else $error("incr pulse");
    AST_PY_AMP: assert property (up |-> pitch_yaw_switch_amp_enable_o ==
        (roll_switch_amp_enable_o && !$past(thrust_vector_mode_cmd_i, 3))) else $error("py amp");
    AST_AMP_STAY: assert property (roll_switch_amp_enable_o |=> roll_switch_amp_enable_o)
        else $error("roll amp dropped");
    AST_ON_DELAY: assert property ($rose(delayed_gyro_power_o) |-> req_q
        && run_q >= ON_LO && run_q <= ON_HI) else $error("on delay");
    // Scenarios
    COV_INCR: cover property (roll_incr_pos_o);
    COV_ON: cover property ($rose(delayed_gyro_power_o));
    COV_OFF: cover property ($fell(inverter_power_on_o));
endmodule // gpr_props
bind gpr_top gpr_props #(.TICK_CYCLES(TICK_CYCLES), .HOLD_TICKS(HOLD_TICKS)) u_props (.*);
`default_nettype wire

// ==== tb/gpr_seq_model.sv ====
// Command source model
`default_nettype none
module gpr_seq_model (
    // Clock
    input wire logic clk_i,
    // Wants, settled, rule-break
    input wire logic [21:0] want_i,
    input wire logic settled_i,
    input wire logic rude_i,
    // Command pins
    output logic [21:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Increments wait for settle unless rude
    wire [21:0] gate = {{2{settled_i | rude_i}}, 20'hfffff};
    // Pins move on the edge
    always @(posedge clk_i) begin
        pin_o <= want_i & gate;
    end
endmodule // gpr_seq_model
`default_nettype wire

// ==== tb/gpr_top_tb.sv ====
// Gyro power block bench
`default_nettype none
module gpr_top_tb;
    import gpr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rude = 1'b0;
    logic [3:0] sel = 4'h0;
    gpr_addr_t adr = 8'h00;
    gpr_word_t wdat = 32'h0, rdat;
    logic [21:0] want = 22'h0, pin; // Wanted and driven pins
    logic [17:0] st; // Outputs in status order
    logic [32:0] expq[$], e; // Bus notes: flag, data
    logic [31:0] seed = 32'h0a556abf, r;
    int err_count = 0, samples_checked = 0, n;
    ////////////////////////////////////////////////////////////////
    gpr_seq_model u_seq (.clk_i, .want_i(want), .settled_i(st[2]), .rude_i(rude), .pin_o(pin));
    gpr_top #(.TICK_CYCLES(17'h4), .HOLD_TICKS(18'h14)) DUT (.clk_i, .rst_i,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .gyro_power_request_i(pin[0]), .star_acquired_i(pin[1]),
        .sun_gate_i(pin[2]), .power_up_acq_flag_i(pin[3]), .flyback_sweep_i(pin[4]), .pyro_arm_switch_i(pin[5]),
        .stray_light_cmd_i(pin[6]), .gyro_on_seq_cmd_i(pin[7]), .inertial_mode_cmd_i(pin[8]),
        .turn_polarity_seq_i(pin[9]), .roll_turn_cmd_i(pin[10]), .roll_turn_raw_i(pin[11]),
        .yaw_turn_cmd_i(pin[12]), .capture_release_cmd_i(pin[13]), .switch_amp_backup_a_i(pin[14]),
        .gyro_on_raw_cmd_i(pin[15]), .thrust_vector_mode_cmd_i(pin[16]), .roll_gyro_direct_latched_i(pin[17]),
        .roll_gyro_force_latched_i(pin[18]), .backup_direct_cmd_thirteen_i(pin[19]),
        .roll_increment_pos_cmd_i(pin[20]), .roll_increment_neg_cmd_i(pin[21]), .inverter_power_on_o(st[0]),
        .delayed_gyro_power_o(st[1]), .gyro_settled_o(st[2]), .roll_gyro_power_o(st[3]),
        .pitch_yaw_gyro_power_o(st[4]), .roll_only_o(st[5]), .pitch_yaw_integ_en_o(st[6]),
        .roll_integ_en_o(st[7]), .negative_turn_o(st[8]), .roll_turn_exec_o(st[9]), .yaw_turn_exec_o(st[10]),
        .roll_incr_pos_o(st[11]), .roll_incr_neg_o(st[12]), .accel_power_o(st[13]),
        .capture_release_o(st[14]), .pitch_yaw_drate_disable_o(st[15]), .roll_switch_amp_enable_o(st[16]),
        .pitch_yaw_switch_amp_enable_o(st[17]));
    ////////////////////////////////////////////////////////////////
    // Clock, watchdog, bus monitor
    initial forever #4 clk_i = ~clk_i;
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        test_done;
    end
    always @(posedge clk_i) begin
        if (ack === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[32]) cmpb(rdat === e[31:0], 32); // Read data against note
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // One comparison
    task automatic cmpb(input logic g, input int k);
        samples_checked++;
        if (g !== 1'b1) begin
            err_count++;
            $display("wrong value t=%0t check %0d", $time, k);
        end
    endtask
    // Classic bus cycle
    task automatic bus(input logic w, input gpr_addr_t a, input gpr_word_t d, input gpr_word_t x);
        expq.push_back({!w, x});
        {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hf};
        do @(posedge clk_i); while (ack !== 1'b1);
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
    endtask
    // Bounded wait for a level
    task automatic waitb(input int i, input logic v);
        n = 0;
        while (st[i] !== v && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        cmpb(st[i] === v, i);
    endtask
    // Pulse a pin, count output pulses
    task automatic pulse(input int i, input int x);
        int c = 0;
        want[i] <= 1'b1;
        repeat (4) @(negedge clk_i) c += int'(st[i - 9]);
        @(posedge clk_i) want[i] <= 1'b0;
        repeat (8) @(negedge clk_i) c += int'(st[i - 9]);
        @(posedge clk_i);
        cmpb(c == x, i);
    endtask
    task automatic hold(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        hold(2);
        rst_i <= 1'b0;
        hold(3);
        bus(1'b0, 8'h00, 32'h0, 32'h0);
        bus(1'b1, 8'h04, 32'hffffffff, 32'h0);
        bus(1'b0, 8'h04, 32'h0, 32'h100);
        bus(1'b0, 8'h08, 32'h0, 32'h0);
        bus(1'b1, 8'h00, 32'h8, 32'h0);
        bus(1'b0, 8'h00, 32'h0, 32'h8);
        bus(1'b1, 8'h00, 32'h0, 32'h0);
        bus(1'b0, 8'h04, 32'h0, 32'h30100);
        $display("test regs done");
        for (int k = 0; k < 16; k++) begin
            r = xs();
            want[12:9] <= r[3:0];
            hold(6);
            cmpb(st[8] === !r[0], 8);
            cmpb(st[9] === r[1], 9);
            cmpb(st[10] === (r[3] & !r[2]), 10);
        end
        want <= 22'h107; // Sun, star, inertial, request
        waitb(1, 1'b1);
        cmpb(n > 340 && st[6] && st[3] && st[4] && st[13] && st[15] && !st[7], 1);
        waitb(2, 1'b1);
        cmpb(st[7] === 1'b1, 7);
        pulse(20, 1);
        pulse(21, 1);
        want[1] <= 1'b0;
        want[8] <= 1'b0;
        hold(7);
        cmpb(st[5] === 1'b0, 5);
        want[0] <= 1'b0;
        hold(8);
        cmpb(!st[1] && st[5] && st[0] && !st[4], 4);
        rude <= 1'b1;
        pulse(20, 0);
        want[7] <= 1'b1;
        hold(8);
        cmpb(st[5] === 1'b0, 5);
        want[7] <= 1'b0;
        hold(8);
        cmpb(st[5] === 1'b1, 5);
        want[2] <= 1'b0;
        hold(8);
        cmpb(st[5] === 1'b0, 5);
        waitb(0, 1'b0);
        want[19:16] <= 4'h9;
        hold(8);
        cmpb(!st[17] && st[16] && !st[8] && st[14], 17);
        $display("test pins done");
        test_done;
    end
endmodule // gpr_top_tb
`default_nettype wire
